// ---- core/lpddr3_ctrl_core.sv ----
// Controller core: bring-up, leveling, read training, bank tracking, issue and data path.
`timescale 1ns/10ps

// What this block does
// - Core logic on core clock, I/O edge clock
// - User data four memory words wide
// - Track open banks and their rows
// - Decode commands by bank and row state
// - Two-deep command queue, decode while issuing
// - Issuer drains queue meeting memory timing
// - Switch termination around memory writes
// - Gear single-rate words to double rate
// - Run init sequence, then flag done
// - Optional leveling after init, before training
// - Done ends leveling; failure flag alongside
// - Read training follows leveling
// - Drive coarse window and fine phase
// - Window rises 6 cycles (5.5 periods rounded up) before preamble
// - Step position until preamble seen
// - Window held for whole read burst
// - Accept only all-pass trials, else shift
// - Keep settings per group, reuse them
// - Deliver read data with valid strobe
// - Align edge-clock elements after reset
// - Hold update request until acknowledged
module lpddr3_ctrl_core
	import lpddr3_ctrl_pkg::*;
#(
	parameter int DW            = 16,
	parameter int NUM_GROUPS    = 2,
	parameter int BANK_W        = 3,
	parameter int ROW_W         = 14,
	parameter int COL_W         = 10,
	parameter int INIT_WAIT_CYC = INIT_WAIT_US * SYS_CLK_MHZ
) (
	input  wire logic                              sys_clk_in,
	input  wire logic                              nrst_in,
	input  wire logic [REG_ADDR_W-1:0]             reg_addr_in,
	input  wire logic [31:0]                       reg_wdata_in,
	input  wire logic                              reg_wr_in,
	input  wire logic                              reg_rd_in,
	output logic      [31:0]                       reg_rdata_out,
	input  wire logic                              init_start_in,
	output logic                                   init_done_out,
	output logic                                   leveling_failure_flag_out,
	input  wire logic [3:0]                        cmd_in,
	input  wire logic                              cmd_valid_in,
	input  wire logic [BANK_W+ROW_W+COL_W-1:0]     addr_in,
	input  wire logic [GEAR_RATIO*DW-1:0]          write_data_in,
	output logic                                   cmd_ready_out,
	output logic      [GEAR_RATIO*DW-1:0]          read_data_out,
	output logic                                   read_data_valid_out,
	output logic      [2:0]                        mem_cmd_out,
	output logic      [BANK_W-1:0]                 mem_bank_out,
	output logic      [ROW_W-1:0]                  mem_addr_out,
	output logic                                   odt_out,
	output logic      [2*DW-1:0]                   dq_out,
	output logic                                   dq_oe_out,
	input  wire logic [2*DW-1:0]                   dq_in,
	input  wire logic                              capture_valid_in,
	input  wire logic [NUM_GROUPS-1:0]             preamble_seen_flag_in,
	output logic      [2*NUM_GROUPS-1:0]           coarse_window_out,
	output logic      [3*NUM_GROUPS-1:0]           fine_capture_phase_out,
	output logic                                   wl_active_out,
	output logic      [5*NUM_GROUPS-1:0]           wl_delay_out,
	input  wire logic [NUM_GROUPS-1:0]             wl_feedback_in,
	input  wire logic                              edge_clk_in,
	output logic                                   sync_start_out,
	output logic                                   dll_update_out,
	input  wire logic                              update_done_in
);
	localparam int QD    = 2;                 // Queue depth.
	localparam int UDW   = GEAR_RATIO * DW;   // User data width.
	localparam int SW    = NUM_GROUPS + 2;    // Synchronised input count.
	localparam int NBANK = 1 << BANK_W;

	// Pin-side inputs from other domains pass two flops before use.
	logic [SW-1:0] sync1_ff;
	logic [SW-1:0] sync2_ff;
	logic          eclk_prev_ff;              // Last synchronised edge clock level.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			sync1_ff     <= '0;
			sync2_ff     <= '0;
			eclk_prev_ff <= 1'b0;
		end else begin
			sync1_ff     <= {wl_feedback_in, update_done_in, edge_clk_in};
			sync2_ff     <= sync1_ff;
			eclk_prev_ff <= sync2_ff[0];
		end
	end
	wire                  eclk_rise = sync2_ff[0] & ~eclk_prev_ff;
	wire                  ack_sync  = sync2_ff[1];
	wire [NUM_GROUPS-1:0] wl_fb     = sync2_ff[SW-1:2];

	init_state_t     st_ff;                    // Bring-up sequence state.
	logic [31:0]     init_cnt_ff;              // Shared wait counter.
	logic [1:0]      mrw_idx_ff;               // Mode writes issued so far.
	logic            wl_en_ff;                 // Leveling enabled by software.
	logic            dll_update_ff;            // Delay lock update request.
	logic            init_done_ff;
	logic            lvl_err_ff;
	logic            trn_err_ff;
	logic [5:0]      timer_ff;                 // Issue spacing timer.
	logic [4:0]      rd_cnt_ff;                // Cycles since last read issue.
	logic [4:0]      wr_cnt_ff;                // Cycles since last write issue.
	logic [NUM_GROUPS-1:0] wl_done_ff;
	logic [NUM_GROUPS-1:0] wl_fail_ff;
	logic [NUM_GROUPS-1:0] tr_lock_ff;
	logic [NUM_GROUPS-1:0] tr_fail_ff;
	logic [NUM_GROUPS-1:0] win_act;            // Capture window per group.
	logic            tr_req;                   // Training read wanted.
	wire             all_wl  = &(wl_done_ff | wl_fail_ff);
	wire             all_tr  = &tr_lock_ff;
	wire             win_end = (rd_cnt_ff == 5'(WIN_END));
	logic            dec_valid_ff;             // Decoder slot holds a command.
	// An update request written this cycle already keeps the next command slot idle.
	wire             dll_start = reg_wr_in && (reg_addr_in == REG_CTRL) && reg_wdata_in[CTRL_DLL];
	wire             mrw_fire = (st_ff == ST_MRW) && (timer_ff == 6'h0) &&
	                            (mrw_idx_ff < 2'(NUM_MRW)) && !dll_update_ff && !dll_start;

	// Bring-up sequence.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			st_ff       <= ST_CLKSYNC;
			init_cnt_ff <= '0;
			mrw_idx_ff  <= 2'h0;
		end else begin
			unique case (st_ff)
				ST_CLKSYNC: begin
					if (eclk_rise) begin
						init_cnt_ff <= init_cnt_ff + 32'h0000_0001;
					end
					if (init_cnt_ff == 32'(SYNC_EDGES)) begin
						st_ff       <= ST_WAIT_START;
						init_cnt_ff <= '0;
					end
				end
				ST_WAIT_START: begin
					if (init_start_in) begin
						st_ff <= ST_POWERUP;
					end
				end
				ST_POWERUP: begin
					init_cnt_ff <= init_cnt_ff + 32'h0000_0001;
					if (init_cnt_ff == 32'(INIT_WAIT_CYC - 1)) begin
						st_ff       <= ST_MRW;
						init_cnt_ff <= '0;
					end
				end
				ST_MRW: begin
					if (mrw_fire) begin
						mrw_idx_ff <= mrw_idx_ff + 2'h1;
					end else if (mrw_idx_ff == 2'(NUM_MRW) && timer_ff == 6'h0) begin
						st_ff <= wl_en_ff ? ST_WLEVEL : ST_TRAIN_REQ;
					end
				end
				ST_WLEVEL: begin
					if (all_wl) begin
						st_ff <= ST_TRAIN_REQ;
					end
				end
				ST_TRAIN_REQ: begin
					// Training read handed to the decoder.
					if (!dec_valid_ff) begin
						st_ff <= ST_TRAIN_WAIT;
					end
				end
				ST_TRAIN_WAIT: begin
					if (win_end) begin
						st_ff <= (all_tr || (&(tr_lock_ff | tr_fail_ff))) ? ST_READY : ST_TRAIN_REQ;
					end
				end
				ST_READY: begin
					// Holds until reset.
				end
			endcase
		end
	end
	assign tr_req = (st_ff == ST_TRAIN_REQ);

	// Clock alignment pulse once the edge clock has been seen running.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			sync_start_out <= 1'b0;
		end else begin
			sync_start_out <= (st_ff == ST_CLKSYNC) && (init_cnt_ff == 32'(SYNC_EDGES));
		end
	end

	// Done and failure flags; done is sticky until reset.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			init_done_ff <= 1'b0;
			lvl_err_ff   <= 1'b0;
			trn_err_ff   <= 1'b0;
		end else if (st_ff == ST_TRAIN_WAIT && win_end && st_ff != ST_READY) begin
			if (all_tr || (&(tr_lock_ff | tr_fail_ff))) begin
				init_done_ff <= 1'b1;
				lvl_err_ff   <= |wl_fail_ff;
				trn_err_ff   <= |tr_fail_ff;
			end
		end
	end
	assign init_done_out             = init_done_ff;
	assign leveling_failure_flag_out = lvl_err_ff;

	// Per-group leveling and read training.
	logic [4:0]      wl_tap_ff  [NUM_GROUPS];
	logic [1:0]      coarse_ff  [NUM_GROUPS];
	logic [2:0]      fine_ff    [NUM_GROUPS];
	logic [2:0]      trial_ff   [NUM_GROUPS];
	logic [NUM_GROUPS-1:0] seen_ff;           // Preamble seen in this window.
	logic [2:0]      wl_step_ff;               // Cycles between tap steps.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in || st_ff != ST_WLEVEL || wl_step_ff == 3'(WL_STEP_CYC - 1)) begin
			wl_step_ff <= 3'h0;
		end else begin
			wl_step_ff <= wl_step_ff + 3'h1;
		end
	end
	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : grp
			// Leveling: step the strobe delay until feedback turns high.
			always_ff @(posedge sys_clk_in) begin
				if (!nrst_in) begin
					wl_tap_ff[g]  <= 5'h0;
					wl_done_ff[g] <= 1'b0;
					wl_fail_ff[g] <= 1'b0;
				end else if (st_ff == ST_WLEVEL && !wl_done_ff[g] && !wl_fail_ff[g] &&
				             wl_step_ff == 3'(WL_STEP_CYC - 1)) begin
					if (wl_fb[g]) begin
						wl_done_ff[g] <= 1'b1;
					end else if (wl_tap_ff[g] == 5'(WL_TAP_MAX)) begin
						wl_fail_ff[g] <= 1'b1;
					end else begin
						wl_tap_ff[g] <= wl_tap_ff[g] + 5'h1;
					end
				end
			end
			// Window per group, shifted later by its coarse setting.
			// Window well ahead of preamble
			assign win_act[g] = (rd_cnt_ff >= 5'(WIN_START) + 5'(coarse_ff[g])) &&
			                    (rd_cnt_ff < 5'(WIN_START + WIN_LEN) + 5'(coarse_ff[g]));
			// Training position and trial counting.
			always_ff @(posedge sys_clk_in) begin
				if (!nrst_in) begin
					coarse_ff[g]  <= 2'h0;
					fine_ff[g]    <= 3'h0;
					trial_ff[g]   <= 3'h0;
					tr_lock_ff[g] <= 1'b0;
					tr_fail_ff[g] <= 1'b0;
					seen_ff[g]    <= 1'b0;
				end else if (st_ff == ST_TRAIN_WAIT) begin
					if (win_act[g] && preamble_seen_flag_in[g]) begin
						seen_ff[g] <= 1'b1;
					end
					if (win_end) begin
						seen_ff[g] <= 1'b0;
						if (!tr_lock_ff[g] && !tr_fail_ff[g]) begin
							if (seen_ff[g]) begin
								trial_ff[g]   <= trial_ff[g] + 3'h1;
								tr_lock_ff[g] <= (trial_ff[g] == 3'(NUM_TRIALS - 1));
							end else begin
								trial_ff[g] <= 3'h0;
								if (fine_ff[g] != 3'(FINE_MAX)) begin
									fine_ff[g] <= fine_ff[g] + 3'h1;
								end else if (coarse_ff[g] != 2'(COARSE_MAX)) begin
									fine_ff[g]   <= 3'h0;
									coarse_ff[g] <= coarse_ff[g] + 2'h1;
								end else begin
									tr_fail_ff[g] <= 1'b1;
								end
							end
						end
					end
				end
			end
			assign coarse_window_out[2*g +: 2]      = win_act[g] ? 2'h3 : 2'h0;
			assign fine_capture_phase_out[3*g +: 3] = fine_ff[g];
			assign wl_delay_out[5*g +: 5]           = wl_tap_ff[g];
		end
	endgenerate
	assign wl_active_out = (st_ff == ST_WLEVEL);

	// Decoder holding slot and bank table.
	logic            dec_wr_ff;
	logic [BANK_W-1:0] dec_bank_ff;
	logic [ROW_W-1:0]  dec_row_ff;
	logic [COL_W-1:0]  dec_col_ff;
	logic [UDW-1:0]    dec_data_ff;
	logic [NBANK-1:0]  bank_open_ff;
	logic [ROW_W-1:0]  bank_row_ff [NBANK];
	// Queue entries.
	mem_cmd_t        q_cmd_ff  [QD];
	logic [BANK_W-1:0] q_bank_ff [QD];
	logic [ROW_W-1:0]  q_addr_ff [QD];
	logic [UDW-1:0]    q_data_ff [QD];
	logic            q_wp_ff;
	logic            q_rp_ff;
	logic [1:0]      q_cnt_ff;
	wire             q_full = (q_cnt_ff == 2'(QD));
	wire             push   = dec_valid_ff && !q_full;
	wire             pop    = (q_cnt_ff != 2'h0) && (timer_ff == 6'h0) &&
	                          !dll_update_ff && !dll_start && !mrw_fire;
	wire             hit    = bank_open_ff[dec_bank_ff] && (bank_row_ff[dec_bank_ff] == dec_row_ff);
	mem_cmd_t        push_cmd;
	logic [ROW_W-1:0] push_addr;

	always_comb begin
		push_cmd  = MCMD_ACT;
		push_addr = dec_row_ff;
		if (hit) begin
			push_cmd  = dec_wr_ff ? MCMD_WR : MCMD_RD;
			push_addr = ROW_W'(dec_col_ff);
		end else if (bank_open_ff[dec_bank_ff]) begin
			push_cmd = MCMD_PRE;
		end
	end
	assign cmd_ready_out = init_done_ff && !dec_valid_ff;

	// Decoder slot: user commands after bring-up, training reads during it.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			dec_valid_ff <= 1'b0;
			dec_wr_ff    <= 1'b0;
			dec_bank_ff  <= '0;
			dec_row_ff   <= '0;
			dec_col_ff   <= '0;
			dec_data_ff  <= '0;
		end else if (!dec_valid_ff) begin
			if (cmd_ready_out && cmd_valid_in && (cmd_in == UCMD_READ || cmd_in == UCMD_WRITE)) begin
				dec_valid_ff <= 1'b1;
				dec_wr_ff    <= (cmd_in == UCMD_WRITE);
				{dec_bank_ff, dec_row_ff, dec_col_ff} <= addr_in;
				dec_data_ff  <= write_data_in;
			end else if (tr_req) begin
				dec_valid_ff <= 1'b1;
				dec_wr_ff    <= 1'b0;
				{dec_bank_ff, dec_row_ff, dec_col_ff} <= '0;
			end
		end else if (push && hit) begin
			dec_valid_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			bank_open_ff <= '0;
		end else if (push && push_cmd == MCMD_PRE) begin
			bank_open_ff[dec_bank_ff] <= 1'b0;
		end else if (push && push_cmd == MCMD_ACT) begin
			bank_open_ff[dec_bank_ff] <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (push && push_cmd == MCMD_ACT) begin
			bank_row_ff[dec_bank_ff] <= dec_row_ff;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			q_wp_ff  <= 1'b0;
			q_rp_ff  <= 1'b0;
			q_cnt_ff <= 2'h0;
		end else begin
			q_wp_ff  <= q_wp_ff ^ push;
			q_rp_ff  <= q_rp_ff ^ pop;
			q_cnt_ff <= q_cnt_ff + 2'(push) - 2'(pop);
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (push) begin
			q_cmd_ff[q_wp_ff]  <= push_cmd;
			q_bank_ff[q_wp_ff] <= dec_bank_ff;
			q_addr_ff[q_wp_ff] <= push_addr;
			q_data_ff[q_wp_ff] <= dec_data_ff;
		end
	end

	// Issuer: one memory command per free slot, then spacing.
	logic [UDW-1:0]  wbuf_ff;                  // Write word for the burst.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			mem_cmd_out  <= MCMD_NOP;
			mem_bank_out <= '0;
			mem_addr_out <= '0;
			timer_ff     <= 6'h0;
			wbuf_ff      <= '0;
		end else begin
			mem_cmd_out <= MCMD_NOP;
			if (timer_ff != 6'h0) begin
				timer_ff <= timer_ff - 6'h1;
			end
			if (mrw_fire) begin
				mem_cmd_out  <= MCMD_MRW;
				mem_addr_out <= ROW_W'(mrw_idx_ff);
				timer_ff     <= 6'(T_MRD_CYC);
			end else if (pop) begin
				mem_cmd_out  <= q_cmd_ff[q_rp_ff];
				mem_bank_out <= q_bank_ff[q_rp_ff];
				mem_addr_out <= q_addr_ff[q_rp_ff];
				unique case (q_cmd_ff[q_rp_ff])
					MCMD_ACT: timer_ff <= 6'(T_RCD_CYC);
					MCMD_PRE: timer_ff <= 6'(T_RP_CYC);
					MCMD_RD:  timer_ff <= 6'(RD_GAP_CYC);
					MCMD_WR:  timer_ff <= 6'(WR_GAP_CYC);
					default:  timer_ff <= 6'h0;
				endcase
				if (q_cmd_ff[q_rp_ff] == MCMD_WR) begin
					wbuf_ff <= q_data_ff[q_rp_ff];
				end
			end
		end
	end
	wire rd_issue = pop && q_cmd_ff[q_rp_ff] == MCMD_RD;
	wire wr_issue = pop && q_cmd_ff[q_rp_ff] == MCMD_WR;

	// Cycle counters since the last read and write, saturating.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			rd_cnt_ff <= 5'h1F;
			wr_cnt_ff <= 5'h1F;
		end else begin
			rd_cnt_ff <= rd_issue ? 5'h0 : (rd_cnt_ff == 5'h1F ? rd_cnt_ff : rd_cnt_ff + 5'h1);
			wr_cnt_ff <= wr_issue ? 5'h0 : (wr_cnt_ff == 5'h1F ? wr_cnt_ff : wr_cnt_ff + 5'h1);
		end
	end

	// Write burst: low half then high half, termination around it.
	wire wr_beat = (wr_cnt_ff >= 5'(WR_LAT_CYC)) && (wr_cnt_ff < 5'(WR_LAT_CYC + BURST_CYC));
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			dq_out    <= '0;
			dq_oe_out <= 1'b0;
			odt_out   <= 1'b0;
		end else begin
			// Four memory words per user word
			dq_oe_out <= wr_beat;
			dq_out    <= (wr_cnt_ff == 5'(WR_LAT_CYC)) ? wbuf_ff[2*DW-1:0] : wbuf_ff[UDW-1:2*DW];
			odt_out   <= wr_issue || (wr_cnt_ff < 5'(WR_LAT_CYC + BURST_CYC));
		end
	end

	// Read capture: two double-rate halves make one user word.
	logic            half_ff;                  // Low half already taken.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			half_ff             <= 1'b0;
			read_data_out       <= '0;
			read_data_valid_out <= 1'b0;
		end else begin
			read_data_valid_out <= 1'b0;
			if (init_done_ff && capture_valid_in && (|win_act)) begin
				half_ff <= !half_ff;
				if (!half_ff) begin
					read_data_out[2*DW-1:0] <= dq_in;
				end else begin
					read_data_out[UDW-1:2*DW] <= dq_in;
					read_data_valid_out       <= 1'b1;
				end
			end else if (!(|win_act)) begin
				half_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			dll_update_ff <= 1'b0;
		end else if (dll_update_ff && ack_sync) begin
			dll_update_ff <= 1'b0;
		end else if (dll_start) begin
			dll_update_ff <= 1'b1;
		end
	end
	assign dll_update_out = dll_update_ff;

	logic [5*NUM_GROUPS-1:0] train_word;       // Coarse and fine per group.
	// Stored training settings gathered for read back.
	always_comb begin
		train_word = '0;
		for (int i = 0; i < NUM_GROUPS; i++) begin
			train_word[5*i +: 5] = {coarse_ff[i], fine_ff[i]};
		end
	end

	// Software registers: leveling enable written, state read back.
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			wl_en_ff      <= 1'b0;
			reg_rdata_out <= '0;
		end else begin
			if (reg_wr_in && reg_addr_in == REG_CTRL) begin
				wl_en_ff <= reg_wdata_in[CTRL_WL_EN];
			end
			reg_rdata_out <= '0;
			if (reg_rd_in) begin
				unique case (reg_addr_in)
					REG_CTRL:   reg_rdata_out[CTRL_WL_EN] <= wl_en_ff;
					REG_STATUS: begin
						reg_rdata_out[STAT_DONE]    <= init_done_ff;
						reg_rdata_out[STAT_LVL_ERR] <= lvl_err_ff;
						reg_rdata_out[STAT_TRN_ERR] <= trn_err_ff;
						reg_rdata_out[STAT_DLL]     <= dll_update_ff;
						reg_rdata_out[STAT_STATE +: 3] <= st_ff;
					end
					REG_TRAIN:  reg_rdata_out[5*NUM_GROUPS-1:0] <= train_word;
					default:    reg_rdata_out <= '0;
				endcase
			end
		end
	end
endmodule

// ---- common/lpddr3_ctrl_pkg.sv ----
// Shared constants and types of the low-power DDR controller core.
package lpddr3_ctrl_pkg;
	// Clock rates in MHz; the nominal core and edge rates, and the rate used here.
	localparam int SYS_CLK_MHZ  = 40;
	localparam int CORE_CLK_MHZ = 200;
	localparam int EDGE_CLK_MHZ = 400;
	// User data words are this many memory data words wide.
	localparam int GEAR_RATIO   = 4;
	localparam int BURST_LEN    = 8;
	localparam int BURST_CYC    = BURST_LEN / GEAR_RATIO;
	// Memory timing in ns, rounded up to whole core cycles.
	localparam int T_RCD_NS     = 18;
	localparam int T_RP_NS      = 18;
	localparam int T_MRD_NS     = 70;
	localparam int T_WR_NS      = 15;
	localparam int T_RCD_CYC    = (T_RCD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int T_RP_CYC     = (T_RP_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int T_MRD_CYC    = (T_MRD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int T_WR_CYC     = (T_WR_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int INIT_WAIT_US = 200;
	localparam int RD_LAT_CYC   = 12;
	localparam int WR_LAT_CYC   = 6;
	// Capture window lead ahead of the preamble, in tenths of a period.
	localparam int WIN_LEAD_TENTHS = 55;
	localparam int WIN_LEAD_CYC = (WIN_LEAD_TENTHS + 9) / 10;
	localparam int WIN_START    = RD_LAT_CYC - WIN_LEAD_CYC;
	localparam int WIN_LEN      = WIN_LEAD_CYC + BURST_CYC;
	localparam int COARSE_MAX   = 3;
	localparam int FINE_MAX     = 7;
	localparam int WIN_END      = WIN_START + COARSE_MAX + WIN_LEN;
	localparam int RD_GAP_CYC   = WIN_END + 1;
	localparam int WR_GAP_CYC   = WR_LAT_CYC + BURST_CYC + T_WR_CYC;
	localparam int NUM_TRIALS   = 4;
	localparam int WL_TAP_MAX   = 31;
	localparam int WL_STEP_CYC  = 4;
	localparam int SYNC_EDGES   = 8;
	localparam int NUM_MRW      = 3;
	// Register map.
	localparam int REG_ADDR_W   = 4;
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_TRAIN  = 4'h8;
	localparam int CTRL_WL_EN   = 0;
	localparam int CTRL_DLL     = 1;
	localparam int STAT_DONE    = 0;
	localparam int STAT_LVL_ERR = 1;
	localparam int STAT_TRN_ERR = 2;
	localparam int STAT_DLL     = 3;
	localparam int STAT_STATE   = 4;
	// User commands.
	localparam logic [3:0] UCMD_READ  = 4'h1;
	localparam logic [3:0] UCMD_WRITE = 4'h2;
	// Memory command codes on the command bus.
	typedef enum logic [2:0] {
		MCMD_NOP = 3'b000, MCMD_ACT = 3'b001, MCMD_RD = 3'b010,
		MCMD_WR = 3'b011, MCMD_PRE = 3'b100, MCMD_MRW = 3'b101
	} mem_cmd_t;
	// Bring-up sequence states.
	typedef enum logic [2:0] {
		ST_CLKSYNC = 3'b000, ST_WAIT_START = 3'b001, ST_POWERUP = 3'b010,
		ST_MRW = 3'b011, ST_WLEVEL = 3'b100, ST_TRAIN_REQ = 3'b101,
		ST_TRAIN_WAIT = 3'b110, ST_READY = 3'b111
	} init_state_t;
endpackage

// ---- verif/lpddr3_ctrl_core_monitor.sv ----
// Port checker for the controller core.
`timescale 1ns/10ps
module lpddr3_ctrl_core_monitor
	import lpddr3_ctrl_pkg::*;
(
	input wire logic       sys_clk_in,
	input wire logic       nrst_in,
	input wire logic       init_done_out,
	input wire logic       leveling_failure_flag_out,
	input wire logic       cmd_ready_out,
	input wire logic       read_data_valid_out,
	input wire logic [2:0] mem_cmd_out,
	input wire logic       odt_out,
	input wire logic       dq_oe_out,
	input wire logic [3:0] coarse_window_out,
	input wire logic       dll_update_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	AST_DONE_HOLD: assert property (init_done_out |=> init_done_out)
		else $error("done fell");
	AST_FAIL_FLAG: assert property ($rose(leveling_failure_flag_out) |-> $rose(init_done_out))
		else $error("flag alone");
	AST_READY: assert property (!init_done_out |-> !cmd_ready_out)
		else $error("early ready");
	AST_WINDOW: assert property ($rose(|coarse_window_out[1:0]) |-> (|coarse_window_out[1:0])[*8])
		else $error("short window");
	AST_REQ_HOLD: assert property ($rose(dll_update_out) |=> dll_update_out[*2])
		else $error("short request");
	AST_REQ_NOP: assert property (dll_update_out |-> mem_cmd_out == MCMD_NOP)
		else $error("busy bus");
	AST_ODT: assert property (mem_cmd_out == MCMD_WR |-> ##[0:1] odt_out)
		else $error("odt off");
	AST_WR_DQ: assert property (mem_cmd_out == MCMD_WR |-> ##[6:7] dq_oe_out)
		else $error("no beat");
	CV_DONE: cover property ($rose(init_done_out));
	CV_READ: cover property (read_data_valid_out);
	CV_UPD: cover property ($fell(dll_update_out));
endmodule
bind lpddr3_ctrl_core lpddr3_ctrl_core_monitor lpddr3_ctrl_core_monitor_inst (.*);

// ---- verif/lpddr3_mem_model.sv ----
// Memory, clock unit and leveling loop model.
`timescale 1ns/10ps
module lpddr3_mem_model
	import lpddr3_ctrl_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic [2:0]  mem_cmd_out,
	input  wire logic        wl_active_out,
	input  wire logic [9:0]  wl_delay_out,
	input  wire logic        dll_update_out,
	output logic      [31:0] dq_in,
	output logic             capture_valid_in,
	output logic      [1:0]  preamble_seen_flag_in,
	output logic      [1:0]  wl_feedback_in,
	output logic             update_done_in
);
	logic [7:0] t_ff = 8'hff; // Cycles since a read; also the idle bus pattern.
	// The burst timer restarts on each read so the preamble lands mid-window.
	always_ff @(posedge sys_clk_in) begin
		t_ff <= (mem_cmd_out == MCMD_RD) ? 8'h00 : t_ff + 8'h01;
		update_done_in <= dll_update_out;
	end
	assign preamble_seen_flag_in = {2{t_ff == 8'h08}};
	assign capture_valid_in = t_ff == 8'h09 || t_ff == 8'h0a;
	assign dq_in = t_ff == 8'h09 ? 32'ha5a5_0001 : t_ff == 8'h0a ? 32'h5a5a_0002 : {4{t_ff}};
	assign wl_feedback_in = {2{wl_active_out}} & {wl_delay_out[9:5] > 5'h02, wl_delay_out[4:0] > 5'h02};
endmodule

// ---- verif/lpddr3_ctrl_init_read_training_tb_top.sv ----
// Bench for the controller core.
`timescale 1ns/10ps
module lpddr3_ctrl_init_read_training_tb_top
	import lpddr3_ctrl_pkg::*;
;
	logic sys_clk_in = '0, nrst_in = '0, edge_clk_in = '0, reg_wr_in = '0, reg_rd_in = '0, init_start_in = '0;
	logic cmd_valid_in = '0, saw_pre = '0, init_done_out, leveling_failure_flag_out, cmd_ready_out, odt_out;
	logic dq_oe_out, read_data_valid_out, capture_valid_in, wl_active_out, sync_start_out, dll_update_out, update_done_in;
	logic [3:0] reg_addr_in = '0, cmd_in = '0, coarse_window_out;
	logic [31:0] reg_wdata_in = '0, reg_rdata_out, dq_in, dq_out, r;
	logic [26:0] addr_in = '0;
	logic [63:0] write_data_in = 64'h1122_3344_5566_7788, read_data_out;
	logic [2:0] mem_cmd_out, mem_bank_out;
	logic [13:0] mem_addr_out;
	logic [1:0] preamble_seen_flag_in, wl_feedback_in;
	logic [5:0] fine_capture_phase_out;
	logic [9:0] wl_delay_out;
	int err_total = 0, n_tests = 0, cyc = 0;
	lpddr3_ctrl_core #(.INIT_WAIT_CYC(10)) lpddr3_ctrl_core_inst (.*);
	lpddr3_mem_model lpddr3_mem_model_inst (.*);
	initial forever #12.5 sys_clk_in = ~sys_clk_in;
	initial #37 forever #100 edge_clk_in = ~edge_clk_in;
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (mem_cmd_out === MCMD_PRE) saw_pre <= '1;
		if (cyc == 4000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(string s, logic [63:0] e, logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge sys_clk_in);
		reg_wr_in <= '0;
		reg_rd_in <= '0;
		@(posedge sys_clk_in);
		r = reg_rdata_out;
	endtask
	task automatic send(logic [3:0] c, logic [13:0] row);
		cmd_in <= c;
		addr_in <= {3'h2, row, 10'h010};
		cmd_valid_in <= '1;
		do @(posedge sys_clk_in); while (cmd_ready_out !== 1'b1);
		cmd_valid_in <= '0;
	endtask
	task automatic t_init;
		chk("width", 2 * $bits(dq_out), $bits(read_data_out));
		bus(1, REG_CTRL, 32'h0000_0001);
		@(posedge sys_clk_in iff sync_start_out === 1'b1);
		init_start_in <= '1;
		repeat (3) @(posedge sys_clk_in);
		init_start_in <= '0;
		chk("ready", 0, cmd_ready_out);
		@(posedge sys_clk_in iff init_done_out === 1'b1);
		chk("lvl flag", 0, leveling_failure_flag_out);
		chk("wl taps", {1'b0, 10'h063, 6'h00}, {wl_active_out, wl_delay_out, fine_capture_phase_out});
		bus(0, REG_STATUS, '0);
		chk("status", 1, r[2:0]);
		bus(0, REG_TRAIN, '0);
		chk("train", 0, r[9:0]);
		bus(0, 4'hc, '0);
		chk("unmapped", 0, r);
		$display("init end");
	endtask
	task automatic t_write;
		send(UCMD_WRITE, 14'h0005);
		@(posedge sys_clk_in iff dq_oe_out === 1'b1);
		chk("odt", 1, odt_out);
		chk("beat0", write_data_in[31:0], dq_out);
		@(posedge sys_clk_in);
		chk("beat1", write_data_in[63:32], dq_out);
		$display("write end");
	endtask
	task automatic t_read(logic [13:0] row, logic pre);
		saw_pre <= '0;
		send(UCMD_READ, row);
		@(posedge sys_clk_in iff read_data_valid_out === 1'b1);
		chk("rdata", 64'h5a5a_0002_a5a5_0001, read_data_out);
		chk("pre", pre, saw_pre);
		chk("bank col", {3'h2, 14'h0010}, {mem_bank_out, mem_addr_out});
		$display("read end");
	endtask
	task automatic t_dll;
		bus(1, REG_CTRL, 32'h0000_0003);
		@(posedge sys_clk_in iff dll_update_out === 1'b1);
		@(posedge sys_clk_in iff dll_update_out === 1'b0);
		chk("ack", 1, update_done_in);
		$display("update end");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk_in);
		nrst_in <= '1;
		t_init();
		t_write();
		t_read(14'h0005, 0);
		t_read(14'h0006, 1);
		t_dll();
		report_and_stop();
	end
endmodule
